// ==== shared/dsw_pkg.sv ====
// Constants and carriers shared by the drive status word block.
// Assumes a single control clock and an APB master with 32-bit data.
package dsw_pkg;

	// ==========================================================
	// Register map.
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] OFS_STATUS  = 12'h000;
	localparam logic [11:0] OFS_CTRL    = 12'h004;
	localparam logic [11:0] OFS_RETAIN  = 12'h008;
	localparam logic [11:0] OFS_EVT     = 12'h00c;
	localparam logic [11:0] OFS_MASK    = 12'h010;

	// ==========================================================
	// Status word bit positions.
	localparam int BIT_VOLT   = 4;
	localparam int BIT_QSTOP  = 5;
	localparam int BIT_SOD    = 6;
	localparam int BIT_ALARM  = 7;
	localparam int BIT_RSV8   = 8;
	localparam int BIT_REMOTE = 9;
	localparam int BIT_ARRIVE = 10;
	localparam int BIT_SLIM   = 11;
	localparam int BIT_IPM    = 12;
	localparam int BIT_RSV13  = 13;
	localparam int BIT_RSV14  = 14;
	localparam int BIT_HOMED  = 15;

	// ==========================================================
	// Control word and retention fields.
	localparam int         CTRL_PAUSE_BIT = 8;
	localparam int         KEEP_DIGIT_LSB = 4;
	localparam logic [3:0] KEEP_DIGIT_VAL = 4'h2;

	// ==========================================================
	// Reset values.
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] RETAIN_RST = 16'h0000;
	localparam logic [3:0]  MASK_RST   = 4'h0;

	// ==========================================================
	// Event bits in the interrupt status and mask registers.
	localparam int N_EVT      = 4;
	localparam int EVT_ALARM  = 0;
	localparam int EVT_HOMED  = 1;
	localparam int EVT_ARRIVE = 2;
	localparam int EVT_SLIM   = 3;

	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic main_voltage;
		logic quick_stop_active;
		logic enable_blocked;
		logic alarm;
		logic remote_ok;
		logic target_reached;
		logic speed_zero;
		logic soft_limit;
		logic interpolated_position_mode;
		logic homing_done;
		logic homing_start;
		logic abs_encoder;
		logic ref_lost;
	} dsw_src_s;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} dsw_apb_req_s;

endpackage

// ==== src/dsw_evt_irq.sv ====
// Sticky event flags with write-one-to-clear and a masked interrupt.
// Assumes clear strobes are one-cycle pulses from the register slave.
`timescale 1ns/10ps
module dsw_evt_irq #(
	parameter int N = 4
) (
	// Clock and reset.
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	// Events, clears and mask.
	input  wire logic [N-1:0] evt_i,
	input  wire logic [N-1:0] clr_i,
	input  wire logic [N-1:0] mask_i,
	// Results.
	output logic      [N-1:0] status_o,
	output logic              irq_o
);
	import dsw_pkg::*;

	typedef struct packed {
		logic [N-1:0] status;
		logic         irq;
	} dsw_irq_st_s;

	dsw_irq_st_s st_q, st_d;

	// ==========================================================
	// Set wins over clear in the same cycle.
	always_comb begin
		st_d        = st_q;
		st_d.status = (st_q.status & ~clr_i) | evt_i;
		st_d.irq    = |(st_d.status & mask_i);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign status_o = st_q.status;
	assign irq_o    = st_q.irq;

	a_evt_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(|evt_i) |=> ((status_o & $past(evt_i)) == $past(evt_i)))
		else $error("Event did not set its sticky flag.");

endmodule

// ==== src/dsw_homing_keep.sv ====
// Homing-complete flag with optional retention for absolute encoders.
// Assumes homing start, done and reference-loss inputs are synchronous.
`timescale 1ns/10ps
module dsw_homing_keep (
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Homing events.
	input  wire logic        homing_done_i,
	input  wire logic        homing_start_i,
	input  wire logic        ref_lost_i,
	// Retention setup.
	input  wire logic        abs_encoder_i,
	input  wire logic [15:0] homing_retention_setting_i,
	// Result.
	output logic             homed_o
);
	import dsw_pkg::*;

	typedef struct packed {
		logic homed;
	} dsw_home_st_s;

	dsw_home_st_s st_q, st_d;
	logic         keep;

	// ==========================================================
	// Flag logic.
	always_comb begin
		keep = abs_encoder_i && (homing_retention_setting_i[KEEP_DIGIT_LSB +: 4] == KEEP_DIGIT_VAL);
		st_d = st_q;
		if (homing_done_i) begin
			st_d.homed = 1'b1;
		end else if (homing_start_i || (ref_lost_i && !keep)) begin
			st_d.homed = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign homed_o = st_q.homed;

	a_homed_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		homing_done_i |=> homed_o) else $error("Homing done did not set flag.");
	a_homed_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(keep && homed_o && !homing_start_i) |=> homed_o)
		else $error("Retained homing flag was lost.");

endmodule

// ==== src/dsw_status_word.sv ====
// Status word bits 4 to 15 of a servo drive, read over APB.
// Assumes drive-internal sources are synchronous to ref_clk_i.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps

module dsw_status_word (
	// Clock and reset.
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,

	// Drive state sources.
	input  wire dsw_pkg::dsw_src_s src_i,

	// APB slave.
	input  wire dsw_pkg::dsw_apb_req_s apb_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,

	// Status word and interrupt.
	output logic [15:0]            status_word_o,
	output logic                   irq_o
);
	import dsw_pkg::*;

	// ==========================================================
	// State.
	typedef struct packed {
		logic [15:0] word;
		logic [15:0] ctrl;
		logic [15:0] retain;
		logic [3:0]  mask;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} dsw_st_s;

	dsw_st_s st_q, st_d;

	logic             homed;
	logic [N_EVT-1:0] evt;
	logic [N_EVT-1:0] evt_clr;
	logic [N_EVT-1:0] evt_status;
	logic             evt_irq;
	logic             pause;
	logic             take;
	logic             done;
	logic             wr_done;
	logic             hit;
	logic             ro;
	logic [31:0]      rdata;

	// ==========================================================
	// Homing flag.
	dsw_homing_keep u_homing (
		.ref_clk_i                  (ref_clk_i),
		.rst_b_i                    (rst_b_i),
		.homing_done_i              (src_i.homing_done),
		.homing_start_i             (src_i.homing_start),
		.ref_lost_i                 (src_i.ref_lost),
		.abs_encoder_i              (src_i.abs_encoder),
		.homing_retention_setting_i (st_q.retain),
		.homed_o                    (homed)
	);

	// ==========================================================
	// Event flags.
	dsw_evt_irq #(
		.N (N_EVT)
	) u_evt (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.evt_i     (evt),
		.clr_i     (evt_clr),
		.mask_i    (st_q.mask),
		.status_o  (evt_status),
		.irq_o     (evt_irq)
	);

	// ==========================================================
	// Bus phases.
	// The first access cycle decodes and raises pready one cycle later.
	// Writes take effect at the edge where pready is sampled high.
	assign take    = apb_i.psel && apb_i.penable && !st_q.pready;
	assign done    = apb_i.psel && apb_i.penable && st_q.pready;
	assign wr_done = done && apb_i.pwrite;
	assign pause   = st_q.ctrl[CTRL_PAUSE_BIT];

	// ==========================================================
	// Rising edges of watched status bits raise events.
	always_comb begin
		evt             = '0;
		evt[EVT_ALARM]  = st_d.word[BIT_ALARM]  && !st_q.word[BIT_ALARM];
		evt[EVT_HOMED]  = st_d.word[BIT_HOMED]  && !st_q.word[BIT_HOMED];
		evt[EVT_ARRIVE] = st_d.word[BIT_ARRIVE] && !st_q.word[BIT_ARRIVE];
		evt[EVT_SLIM]   = st_d.word[BIT_SLIM]   && !st_q.word[BIT_SLIM];
	end

	// ==========================================================
	// Write-one-to-clear strobe for the event flags.
	always_comb begin
		evt_clr = '0;
		if (wr_done && (apb_i.paddr == OFS_EVT)) begin
			evt_clr = apb_i.pwdata[N_EVT-1:0];
		end
	end

	// ==========================================================
	// Read decode.
	always_comb begin
		rdata = '0;
		hit   = 1'b1;
		ro    = 1'b0;
		unique case (apb_i.paddr)
			OFS_STATUS: begin
				rdata[15:0] = st_q.word;
				ro          = 1'b1;
			end
			OFS_CTRL: begin
				rdata[15:0] = st_q.ctrl;
			end
			OFS_RETAIN: begin
				rdata[15:0] = st_q.retain;
			end
			OFS_EVT: begin
				rdata[N_EVT-1:0] = evt_status;
			end
			OFS_MASK: begin
				rdata[N_EVT-1:0] = st_q.mask;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state.
	always_comb begin
		st_d = st_q;

		st_d.word                = '0;
		st_d.word[BIT_VOLT]      = src_i.main_voltage && !src_i.enable_blocked;
		st_d.word[BIT_QSTOP]     = !src_i.quick_stop_active;
		st_d.word[BIT_SOD]       = src_i.enable_blocked;
		st_d.word[BIT_ALARM]     = src_i.alarm;
		st_d.word[BIT_REMOTE]    = src_i.remote_ok;
		st_d.word[BIT_ARRIVE]    = pause ? src_i.speed_zero : src_i.target_reached;
		st_d.word[BIT_SLIM]      = src_i.soft_limit;
		st_d.word[BIT_IPM]       = src_i.interpolated_position_mode;
		st_d.word[BIT_HOMED]     = homed;

		st_d.pready  = take;
		st_d.pslverr = 1'b0;
		if (take) begin
			st_d.prdata  = apb_i.pwrite ? 32'h0000_0000 : rdata;
			st_d.pslverr = !hit || (ro && apb_i.pwrite);
		end

		if (wr_done) begin
			unique case (apb_i.paddr)
				OFS_CTRL: begin
					st_d.ctrl = apb_i.pwdata[15:0];
				end
				OFS_RETAIN: begin
					st_d.retain = apb_i.pwdata[15:0];
				end
				OFS_MASK: begin
					st_d.mask = apb_i.pwdata[N_EVT-1:0];
				end
				default: begin
					st_d.ctrl = st_q.ctrl;
				end
			endcase
		end

		st_d.irq = evt_irq;
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			st_q         <= '0;
			st_q.word    <= STATUS_RST;
			st_q.ctrl    <= CTRL_RST;
			st_q.retain  <= RETAIN_RST;
			st_q.mask    <= MASK_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs.
	assign status_word_o = st_q.word;
	assign prdata_o      = st_q.prdata;
	assign pready_o      = st_q.pready;
	assign pslverr_o     = st_q.pslverr;
	assign irq_o         = st_q.irq;

	// ==========================================================
	// Checks.
	a_qstop_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> (status_word_o[BIT_QSTOP] == !$past(src_i.quick_stop_active)))
		else $error("Quick stop bit wrong.");

	a_sod_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		src_i.enable_blocked |=> status_word_o[BIT_SOD] && !status_word_o[BIT_VOLT])
		else $error("Switch-on disabled bit wrong.");

	a_alarm_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> (status_word_o[BIT_ALARM] == $past(src_i.alarm)))
		else $error("Alarm bit wrong.");

	a_remote_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> (status_word_o[BIT_REMOTE] == $past(src_i.remote_ok)))
		else $error("Remote bit wrong.");

	a_arrive_pause: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(pause && !src_i.speed_zero) |=> !status_word_o[BIT_ARRIVE])
		else $error("Arrival bit high while decelerating.");

	a_arrive_run: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!pause && src_i.target_reached) |=> status_word_o[BIT_ARRIVE])
		else $error("Arrival bit low at target.");

	a_slim_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> (status_word_o[BIT_SLIM] == $past(src_i.soft_limit)))
		else $error("Soft limit bit wrong.");

	a_ipm_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> (status_word_o[BIT_IPM] == $past(src_i.interpolated_position_mode)))
		else $error("Interpolation mode bit wrong.");

	a_rsv_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!status_word_o[BIT_RSV8] && !status_word_o[BIT_RSV13] && !status_word_o[BIT_RSV14])
		else $error("Reserved bit set.");

	a_homed_word: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		src_i.homing_done |-> ##2 status_word_o[BIT_HOMED])
		else $error("Homing bit not in status word.");

	a_volt_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(src_i.main_voltage && !src_i.enable_blocked) |=> status_word_o[BIT_VOLT])
		else $error("Voltage enabled bit wrong.");

	a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		take |=> pready_o ##1 !pready_o)
		else $error("Bus answer not one cycle.");

	a_sod_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!src_i.enable_blocked |=> !status_word_o[BIT_SOD])
		else $error("Switch-on disabled bit stuck high.");

	a_volt_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!(src_i.main_voltage && !src_i.enable_blocked) |=> !status_word_o[BIT_VOLT])
		else $error("Voltage enabled bit stuck high.");

	a_arrive_stopped: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(pause && src_i.speed_zero) |=> status_word_o[BIT_ARRIVE])
		else $error("Arrival bit low at zero speed.");

	a_arrive_moving: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!pause && !src_i.target_reached) |=> !status_word_o[BIT_ARRIVE])
		else $error("Arrival bit high before target.");

	a_low_bits_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		status_word_o[3:0] == 4'h0)
		else $error("Lower status bits set.");

	a_homed_cleared: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(src_i.homing_start && !src_i.homing_done) |-> ##2 !status_word_o[BIT_HOMED])
		else $error("Homing start did not clear homing bit.");

	a_homed_lost: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(src_i.ref_lost && !src_i.homing_done
			&& !(src_i.abs_encoder && (st_q.retain[KEEP_DIGIT_LSB +: 4] == KEEP_DIGIT_VAL)))
		|-> ##2 !status_word_o[BIT_HOMED])
		else $error("Lost reference did not clear homing bit.");

	a_homed_retained: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(src_i.ref_lost && !src_i.homing_start && homed && src_i.abs_encoder
			&& (st_q.retain[KEEP_DIGIT_LSB +: 4] == KEEP_DIGIT_VAL))
		|-> ##2 status_word_o[BIT_HOMED])
		else $error("Retained homing bit was lost.");

	// ==========================================================
	// Bus and interrupt checks.

	a_ready_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!apb_i.psel |=> !pready_o)
		else $error("Ready raised without a transfer.");

	a_err_with_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		pslverr_o |-> pready_o)
		else $error("Error flagged outside an answer.");

	a_err_unmapped: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(take && !hit) |=> pslverr_o)
		else $error("Unmapped access not refused.");

	a_err_status_wr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(take && apb_i.pwrite && (apb_i.paddr == OFS_STATUS)) |=> pslverr_o)
		else $error("Status word write not refused.");

	a_ok_mapped: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(take && hit && !(ro && apb_i.pwrite)) |=> !pslverr_o)
		else $error("Legal access refused.");

	a_wr_data_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(take && apb_i.pwrite) |=> (prdata_o == 32'h0000_0000))
		else $error("Read data not zero on a write answer.");

	a_rd_status: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(take && !apb_i.pwrite && (apb_i.paddr == OFS_STATUS))
		|=> (prdata_o == {16'h0000, $past(status_word_o)}))
		else $error("Status read does not match the word.");

	a_ctrl_land: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wr_done && (apb_i.paddr == OFS_CTRL)) |=> (pause == $past(apb_i.pwdata[CTRL_PAUSE_BIT])))
		else $error("Pause bit write did not land.");

	a_retain_land: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wr_done && (apb_i.paddr == OFS_RETAIN)) |=> (st_q.retain == $past(apb_i.pwdata[15:0])))
		else $error("Retention setting write did not land.");

	a_irq_raise: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(|(evt_status & st_q.mask & ~evt_clr)) |-> ##2 irq_o)
		else $error("Interrupt not raised for an unmasked event.");

	a_irq_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(((evt_status & st_q.mask) == '0) && (evt == '0)) |-> ##2 !irq_o)
		else $error("Interrupt raised with no unmasked event.");

endmodule

// ==== verif/drive_status_word_upper_bits_tb.sv ====
// Self-checking bench for the drive status word block.
// Assumes the block answers APB with pready and samples sources each cycle.
`timescale 1ns/10ps
module drive_status_word_upper_bits_tb;
	import dsw_pkg::*;

	typedef struct packed {
		dsw_src_s    s;
		logic        p;
		logic [15:0] e;
	} dsw_row_s;

	logic          ref_clk = 1'b0;
	logic          rst_b;
	dsw_src_s      src;
	dsw_apb_req_s  apb;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic [15:0]   sw;
	logic          irq;
	int            err_count = 0;
	int            check_count = 0;
	int            cyc = 0;
	dsw_row_s      rows [12] = '{
		'{13'h0000, 1'b0, 16'h0020}, '{13'h1000, 1'b0, 16'h0030}, '{13'h1400, 1'b0, 16'h0060},
		'{13'h0800, 1'b0, 16'h0000}, '{13'h0200, 1'b0, 16'h00a0}, '{13'h0100, 1'b0, 16'h0220},
		'{13'h0080, 1'b0, 16'h0420}, '{13'h0040, 1'b0, 16'h0020}, '{13'h0080, 1'b1, 16'h0020},
		'{13'h0040, 1'b1, 16'h0420}, '{13'h0020, 1'b0, 16'h0820}, '{13'h0010, 1'b0, 16'h1020}};

	dsw_status_word DUT (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .src_i(src), .apb_i(apb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .status_word_o(sw), .irq_o(irq));
	dsw_master_model u_far (.ref_clk_i(ref_clk), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .apb_o(apb));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Compares, bus access and closing report.
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] rd;
		logic        er;
		u_far.xfer(w, a, d, rd, er);
		chk_bit(er, ee);
		if (!w) begin
			chk_word(rd, d);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic pulse_src(input dsw_src_s m);
		src <= src | m;
		wait_n(1);
		src <= src & ~m;
		wait_n(3);
	endtask

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			close_out();
		end
	end

	// ==========================================================
	// Main sequence.
	initial begin
		rst_b = 1'b0;
		src = '0;
		wait_n(4);
		chk_word({16'h0, sw}, 32'h0);
		chk_bit(irq, 1'b0);
		rst_b <= 1'b1;
		acc(1'b0, OFS_CTRL, 32'h0, 1'b0);
		acc(1'b0, OFS_RETAIN, 32'h0, 1'b0);
		acc(1'b0, OFS_EVT, 32'h0, 1'b0);
		acc(1'b0, OFS_MASK, 32'h0, 1'b0);
		$display("test reset done");
		foreach (rows[i]) begin
			acc(1'b1, OFS_CTRL, {23'h0, rows[i].p, 8'h0}, 1'b0);
			src <= rows[i].s;
			wait_n(3);
			chk_word({16'h0, sw}, {16'h0, rows[i].e});
			acc(1'b0, OFS_STATUS, {16'h0, rows[i].e}, 1'b0);
		end
		$display("test table done");
		src <= '0;
		acc(1'b0, OFS_EVT, 32'hd, 1'b0);
		chk_bit(irq, 1'b0);
		acc(1'b1, OFS_MASK, 32'h1, 1'b0);
		wait_n(3);
		chk_bit(irq, 1'b1);
		acc(1'b1, OFS_EVT, 32'h1, 1'b0);
		wait_n(2);
		chk_bit(irq, 1'b0);
		acc(1'b0, OFS_EVT, 32'hc, 1'b0);
		$display("test irq done");
		acc(1'b0, 12'h014, 32'h0, 1'b1);
		acc(1'b1, OFS_STATUS, 32'hffff, 1'b1);
		acc(1'b0, OFS_STATUS, 32'h0020, 1'b0);
		$display("test refusal done");
		pulse_src(13'h0008);
		chk_bit(sw[15], 1'b1);
		pulse_src(13'h0001);
		chk_bit(sw[15], 1'b0);
		src <= 13'h0002;
		acc(1'b1, OFS_RETAIN, 32'h0020, 1'b0);
		pulse_src(13'h0008);
		pulse_src(13'h0001);
		chk_bit(sw[15], 1'b1);
		acc(1'b1, OFS_RETAIN, 32'h0030, 1'b0);
		pulse_src(13'h0001);
		chk_bit(sw[15], 1'b0);
		pulse_src(13'h0008);
		pulse_src(13'h0004);
		chk_bit(sw[15], 1'b0);
		$display("test homing done");
		rst_b <= 1'b0;
		wait_n(2);
		chk_word({16'h0, sw}, 32'h0);
		chk_bit(irq, 1'b0);
		rst_b <= 1'b1;
		wait_n(2);
		chk_word({16'h0, sw}, 32'h0020);
		acc(1'b0, OFS_RETAIN, 32'h0, 1'b0);
		acc(1'b0, OFS_CTRL, 32'h0, 1'b0);
		$display("test mid reset done");
		close_out();
	end
endmodule

// ==== verif/dsw_master_model.sv ====
// Fieldbus-side APB master that reads and writes the status block.
// Assumes one clock; the bench timeout ends a wait that never sees pready.
`timescale 1ns/10ps
module dsw_master_model (
	// Clock.
	input  wire logic              ref_clk_i,
	// Answer from the slave.
	input  wire logic [31:0]       prdata_i,
	input  wire logic              pready_i,
	input  wire logic              pslverr_i,
	// Request to the slave.
	output dsw_pkg::dsw_apb_req_s  apb_o
);
	import dsw_pkg::*;

	initial apb_o = '0;

	// ==========================================================
	// One transfer: setup, access, hold until pready is sampled.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge ref_clk_i);
		apb_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge ref_clk_i);
		apb_o.penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
		end while (pready_i !== 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		apb_o <= '0;
	endtask
endmodule
